// File: design/aspc_filter.v
// First-order low-pass filter on the angle stream
`timescale 1ns/1ps
`include "aspc_map.vh"
module aspc_filter (
	// Clock and reset
	input  wire                        core_clk,
	input  wire                        sys_rst,
	// Control
	input  wire                        run,
	input  wire                        step,
	input  wire                        preload,
	input  wire [`ASPC_FW_W-1:0]       filter_window,
	// Data
	input  wire [`ASPC_ANGLE_W-1:0]    sample,
	output reg  [`ASPC_ANGLE_W-1:0]    filtered
);
	// Fractional accumulator: angle in upper bits, 16 fraction bits
	reg  [31:0] acc;
	wire [15:0] diff = sample - acc[31:16];
	wire [31:0] diff_ext = {{16{diff[15]}}, diff};
	wire [31:0] delta = $signed(diff_ext) <<< (5'd16 - {1'b0, filter_window});

	always @(posedge core_clk) begin
		if (sys_rst) begin
			acc      <= 32'h0000_0000;
			filtered <= 16'h0000;
		end else if (run && step) begin
			if (preload) begin
				acc <= {sample, 16'h0000};
				filtered <= sample;
			end else begin
				// Wrap-aware step toward the new sample
				acc <= acc + delta;
				filtered <= acc[31:16] + delta[31:16];
			end
		end
	end
endmodule // aspc_filter

// File: design/aspc_map.vh
// Constants for the angle sensor power cycling block
`ifndef ASPC_MAP_VH
`define ASPC_MAP_VH
`define ASPC_ANGLE_W      16
`define ASPC_FW_W         4
`define ASPC_TIME_W       16
`define ASPC_CLK_HZ       40000000
`define ASPC_SAMPLE_HZ    1000000
`define ASPC_SAMPLE_CYC   (`ASPC_CLK_HZ / `ASPC_SAMPLE_HZ)
`define ASPC_DIV_W        6
`define ASPC_LP_DIV       8'd40
`define ASPC_LP_W         8
`define ASPC_MODE_W       2
`define ASPC_MODE_ACTIVE  2'h0
`define ASPC_MODE_IDLE    2'h1
`define ASPC_MODE_ASC     2'h2
`define ASPC_ST_W         2
`define ASPC_ST_WAIT      2'h0
`define ASPC_ST_ACTIVE    2'h1
`define ASPC_ST_IDLE      2'h2
`define ASPC_ST_ASC_ON    2'h3
`endif

// File: design/aspc_top.v
// Angle conditioning and power mode control
`timescale 1ns/1ps
`include "aspc_map.vh"
module aspc_top (
	// Clock and reset
	input  wire                        core_clk,
	input  wire                        sys_rst,
	// Front end
	input  wire [`ASPC_ANGLE_W-1:0]    fe_angle,
	output reg                         fe_enable,
	output reg                         fe_strobe,
	// Configuration
	input  wire [`ASPC_FW_W-1:0]       filter_window,
	input  wire                        dir_reverse,
	input  wire [`ASPC_ANGLE_W-1:0]    zero_angle,
	input  wire                        cfg_asc,
	input  wire [`ASPC_TIME_W-1:0]     active_time,
	input  wire [`ASPC_TIME_W-1:0]     cycle_period,
	// Mode pins and chip select
	input  wire                        ext_ctrl,
	input  wire                        pin_enable,
	input  wire                        pin_auto_sampling_cycle,
	input  wire                        cs_n,
	// Status and output buffer
	output reg  [`ASPC_ANGLE_W-1:0]    out_angle,
	output reg                         out_frozen,
	output reg                         out_update,
	output reg  [`ASPC_ST_W-1:0]       power_state
);
	localparam ST_WAIT   = `ASPC_ST_WAIT;
	localparam ST_ACTIVE = `ASPC_ST_ACTIVE;
	localparam ST_IDLE   = `ASPC_ST_IDLE;
	localparam ST_ASC_ON = `ASPC_ST_ASC_ON;

	reg  [`ASPC_DIV_W-1:0]   us_cnt;
	reg                      us_tick;
	reg  [`ASPC_LP_W-1:0]    lp_cnt;
	reg                      lp_tick;
	reg  [`ASPC_TIME_W-1:0]  cyc_cnt;
	reg  [`ASPC_ST_W-1:0]    state;
	reg  [`ASPC_ST_W-1:0]    next_state;
	reg                      cs_n_q;
	reg                      first;
	reg  [`ASPC_MODE_W-1:0]  mode;
	wire                     running;
	wire                     sensing;
	wire                     filt_step;
	wire [`ASPC_ANGLE_W-1:0] filtered;
	reg  [`ASPC_ANGLE_W-1:0] cond_angle;
	wire                     asc_end;

	// Low-power tick count reaches a limit on this tick
	function limit_hit;
		input [`ASPC_TIME_W-1:0] count;
		input [`ASPC_TIME_W-1:0] limit;
		begin
			limit_hit = ({1'b0, count} + 1'b1 >= {1'b0, limit});
		end
	endfunction

	// Mode selection from pins or internal setting
	always @* begin
		if (ext_ctrl) begin
			if (!pin_enable)
				mode = `ASPC_MODE_IDLE;
			else if (pin_auto_sampling_cycle)
				mode = `ASPC_MODE_ASC;
			else
				mode = `ASPC_MODE_ACTIVE;
		end else begin
			mode = cfg_asc ? `ASPC_MODE_ASC : `ASPC_MODE_ACTIVE;
		end
	end

	// Microsecond sample tick
	always @(posedge core_clk) begin
		if (sys_rst) begin
			us_cnt  <= {`ASPC_DIV_W{1'b0}};
			us_tick <= 1'b0;
		end else if (us_cnt == `ASPC_SAMPLE_CYC - 1) begin
			us_cnt  <= {`ASPC_DIV_W{1'b0}};
			us_tick <= 1'b1;
		end else begin
			us_cnt  <= us_cnt + 1'b1;
			us_tick <= 1'b0;
		end
	end

	// Low-power clock tick, free running
	always @(posedge core_clk) begin
		if (sys_rst) begin
			lp_cnt  <= {`ASPC_LP_W{1'b0}};
			lp_tick <= 1'b0;
		end else if (lp_cnt == `ASPC_LP_DIV - 1'b1) begin
			lp_cnt  <= {`ASPC_LP_W{1'b0}};
			lp_tick <= 1'b1;
		end else begin
			lp_cnt  <= lp_cnt + 1'b1;
			lp_tick <= 1'b0;
		end
	end

	// Cycle timer: active from 0 to active_time, idle until cycle_period
	assign asc_end = lp_tick && limit_hit(cyc_cnt, active_time);

	always @* begin
		next_state = state;
		case (state)
			ST_WAIT: begin
				if (cs_n)
					next_state = (mode == `ASPC_MODE_IDLE) ? ST_IDLE :
					             (mode == `ASPC_MODE_ASC) ? ST_ASC_ON : ST_ACTIVE;
			end
			ST_ACTIVE: begin
				if (mode == `ASPC_MODE_IDLE)
					next_state = ST_IDLE;
				else if (mode == `ASPC_MODE_ASC)
					next_state = ST_ASC_ON;
			end
			ST_ASC_ON: begin
				if (mode == `ASPC_MODE_IDLE)
					next_state = ST_IDLE;
				else if (mode == `ASPC_MODE_ACTIVE)
					next_state = ST_ACTIVE;
				else if (asc_end)
					next_state = ST_IDLE;
			end
			ST_IDLE: begin
				if (mode == `ASPC_MODE_ACTIVE)
					next_state = ST_ACTIVE;
				else if (mode == `ASPC_MODE_ASC && lp_tick &&
				         limit_hit(cyc_cnt, cycle_period))
					next_state = ST_ASC_ON;
			end
			default: next_state = ST_WAIT;
		endcase
	end

	always @(posedge core_clk) begin
		if (sys_rst) begin
			state   <= ST_WAIT;
			cyc_cnt <= {`ASPC_TIME_W{1'b0}};
		end else begin
			state <= next_state;
			if (next_state == ST_ASC_ON && state != ST_ASC_ON)
				cyc_cnt <= {`ASPC_TIME_W{1'b0}};
			else if (lp_tick && mode == `ASPC_MODE_ASC)
				cyc_cnt <= cyc_cnt + 1'b1;
		end
	end

	// Front end and filter run only in active phases
	assign running   = (state == ST_ACTIVE) || (state == ST_ASC_ON);
	// No sample until the front end has been powered for a cycle
	assign sensing   = running && fe_enable;
	assign filt_step = us_tick;

	// Restart the filter from the first sample of each wake-up
	always @(posedge core_clk) begin
		if (sys_rst)
			first <= 1'b1;
		else if (!running)
			first <= 1'b1;
		else if (sensing && us_tick)
			first <= 1'b0;
	end

	aspc_filter u_filter (
		.core_clk      (core_clk),
		.sys_rst       (sys_rst),
		.run           (sensing),
		.step          (filt_step),
		.preload       (first),
		.filter_window (filter_window),
		.sample        (fe_angle),
		.filtered      (filtered)
	);

	// Zero reference then direction
	always @* begin
		cond_angle = filtered - zero_angle;
		if (dir_reverse)
			cond_angle = {`ASPC_ANGLE_W{1'b0}} - cond_angle;
	end

	// Output buffer, frozen while chip select low
	always @(posedge core_clk) begin
		if (sys_rst) begin
			cs_n_q      <= 1'b1;
			out_frozen  <= 1'b0;
			out_angle   <= {`ASPC_ANGLE_W{1'b0}};
			out_update  <= 1'b0;
			fe_enable   <= 1'b0;
			fe_strobe   <= 1'b0;
			power_state <= ST_WAIT;
		end else begin
			cs_n_q      <= cs_n;
			fe_enable   <= running;
			fe_strobe   <= sensing && us_tick;
			power_state <= state;
			out_update  <= 1'b0;
			if (cs_n_q && !cs_n)
				out_frozen <= 1'b1;
			else if (!cs_n_q && cs_n)
				out_frozen <= 1'b0;
			// Load from conditioned angle; idle holds last value
			if (!(out_frozen || (cs_n_q && !cs_n))) begin
				if (state == ST_ACTIVE && us_tick && !first) begin
					out_angle  <= cond_angle;
					out_update <= 1'b1;
				end else if (state == ST_ASC_ON && next_state == ST_IDLE &&
				             !first) begin
					out_angle  <= cond_angle;
					out_update <= 1'b1;
				end
			end
		end
	end
endmodule // aspc_top

// File: testbench/aspc_fe_model.sv
// Front-end model supplying the angle word
`timescale 1ns/1ps
module aspc_fe_model (
	// Clock
	input  wire        core_clk,
	// Front end
	input  wire        fe_enable,
	input  wire [15:0] target,
	output wire [15:0] fe_angle
);
	reg [15:0] junk = 16'h5a5a;
	// Powered down: word churns so stale data is never read
	always @(posedge core_clk)
		junk <= ~junk;
	assign fe_angle = fe_enable ? target : junk;
endmodule // aspc_fe_model

// File: testbench/aspc_top_monitor.sv
// Checker for the power cycling block ports
`timescale 1ns/1ps
`include "aspc_map.vh"
module aspc_top_monitor (
	// Clock and reset
	input wire                     core_clk,
	input wire                     sys_rst,
	// Watched ports
	input wire                     fe_enable,
	input wire                     fe_strobe,
	input wire                     cs_n,
	input wire [`ASPC_ANGLE_W-1:0] out_angle,
	input wire                     out_frozen,
	input wire                     out_update,
	input wire [`ASPC_ST_W-1:0]    power_state
);
	reg [7:0] gap;
	// Cycles since last strobe, saturating
	always @(posedge core_clk)
		gap <= sys_rst ? 8'hff : fe_strobe ? 8'h00 : (gap == 8'hff ? gap : gap + 8'h01);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	sequence idle_seen; power_state == `ASPC_ST_IDLE; endsequence
	sequence act_seen; power_state == `ASPC_ST_ACTIVE && cs_n; endsequence
	sequence cyc_end; out_update && power_state == `ASPC_ST_ASC_ON; endsequence
	a_strobe_spacing: assert property (fe_strobe |-> gap >= 8'd39)
		else $error("strobe spacing short");
	a_idle_sensing_off: assert property (
		idle_seen [*3] |-> !$past(fe_enable) && !fe_strobe)
		else $error("front end runs in idle");
	a_wait_quiet: assert property (
		power_state == `ASPC_ST_WAIT |-> !fe_strobe && !out_update)
		else $error("activity before select high");
	a_freeze_on_fall: assert property ($fell(cs_n) |=> out_frozen)
		else $error("buffer not frozen");
	a_release_on_rise: assert property ($rose(cs_n) |=> !out_frozen)
		else $error("buffer not released");
	a_frozen_no_load: assert property (out_frozen |-> !out_update)
		else $error("load while frozen");
	a_angle_on_update: assert property (
		!out_update |-> $stable(out_angle))
		else $error("angle changed without update");
	a_active_refresh: assert property (
		act_seen [*2] |-> ##[0:90] (out_update || power_state != `ASPC_ST_ACTIVE || !cs_n))
		else $error("no refresh in active");
	a_cycle_end_idle: assert property (
		cyc_end |-> ##[1:2] idle_seen)
		else $error("no idle after cycle update");
	a_idle_no_update: assert property (idle_seen |-> !out_update)
		else $error("update while idle");
endmodule // aspc_top_monitor
bind aspc_top aspc_top_monitor mon (.core_clk, .sys_rst, .fe_enable, .fe_strobe, .cs_n,
	.out_angle, .out_frozen, .out_update, .power_state);

// File: testbench/tb_aspc_top.sv
// Self-checking bench for the power cycling block
`timescale 1ns/1ps
`include "aspc_map.vh"
`define CHK(nm, e, a) begin checked++; if ((a) !== (e)) begin fails++; \
	$display("ERROR %s exp %h got %h", nm, e, a); end end
module tb_aspc_top;
	reg         core_clk = 0, sys_rst = 1, dir_reverse = 0, cfg_asc = 0, ext_ctrl = 0;
	reg         pin_enable = 0, pin_auto_sampling_cycle = 0, cs_n = 0;
	reg  [3:0]  filter_window = 4'h0;
	reg  [15:0] zero_angle = 16'h0, active_time = 16'h3, cycle_period = 16'ha;
	reg  [15:0] target = 16'h0, hold, want;
	wire [15:0] fe_angle, out_angle;
	wire        fe_enable, fe_strobe, out_frozen, out_update;
	wire [1:0]  power_state;
	integer     fails = 0, checked = 0, cyc = 0, n, i;
	aspc_top uut (.core_clk, .sys_rst, .fe_angle, .fe_enable, .fe_strobe, .filter_window,
		.dir_reverse, .zero_angle, .cfg_asc, .active_time, .cycle_period, .ext_ctrl,
		.pin_enable, .pin_auto_sampling_cycle, .cs_n, .out_angle, .out_frozen,
		.out_update, .power_state);
	aspc_fe_model fe (.core_clk, .fe_enable, .target, .fe_angle);
	always #12.5 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails++;
			wrap_up;
		end
	end
	task tick(input integer k); repeat (k) @(posedge core_clk); endtask
	task wait_upd;
		n = 0;
		do begin @(posedge core_clk); n++; end while (out_update !== 1'b1 && n < 2000);
	endtask
	function [15:0] exp_angle(input [15:0] x, z, input d);
		exp_angle = d ? -(x - z) : x - z;
	endfunction
	task wrap_up;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		void'($urandom(26369));
		tick(2);
		sys_rst <= 0;
		tick(20);
		`CHK("wait", `ASPC_ST_WAIT, power_state)
		cs_n <= 1;
		for (i = 0; i < 12; i++) begin
			ext_ctrl <= 1;
			pin_enable <= 0;
			tick(100);
			hold = out_angle;
			`CHK("idle", `ASPC_ST_IDLE, power_state)
			`CHK("fe_off", 1'b0, fe_enable)
			target <= $urandom;
			filter_window <= $urandom;
			dir_reverse <= (i == 0) ? 1'b0 : $urandom;
			tick(100);
			`CHK("idle_hold", hold, out_angle)
			zero_angle <= (i == 0) ? 16'h0 : $urandom;
			pin_enable <= 1;
			ext_ctrl <= (i > 5);
			tick(200);
			want = exp_angle(target, zero_angle, dir_reverse);
			`CHK("angle", want, out_angle)
		end
		// Quarter-turn step under a slow window: buffer frozen, then lagging
		cs_n <= 0;
		tick(2);
		hold = out_angle;
		target <= target + 16'h4000;
		filter_window <= 4'h2;
		tick(200);
		`CHK("frozen", 1'b1, out_frozen)
		`CHK("freeze", hold, out_angle)
		cs_n <= 1;
		tick(80);
		want = exp_angle(target, zero_angle, dir_reverse);
		`CHK("released", 1'b0, out_frozen)
		`CHK("filter_lag", 1'b1, out_angle != hold && out_angle != want)
		tick(2000);
		hold = out_angle - want + 16'h1;
		`CHK("filter", 1'b1, hold <= 16'h2)
		for (i = 0; i < 2; i++) begin
			ext_ctrl <= i;
			pin_auto_sampling_cycle <= 1;
			cfg_asc <= 1;
			active_time <= 16'h2 + i;
			cycle_period <= 16'ha - i * 3;
			wait_upd;
			wait_upd;
			wait_upd;
			`CHK("cycle_len", (10 - i * 3) * 40, n)
			want = exp_angle(target, zero_angle, dir_reverse);
			`CHK("asc_angle", want, out_angle)
		end
		wrap_up;
	end
endmodule // tb_aspc_top
